//--- hdl/serial_port_pkg.sv
/*
  Package for the serial port with modem-signal handshake: rate table,
  character lengths, flow policies, register map and reset values.
  Assumes a 100 MHz system clock and a single asynchronous reset.
*/
package serial_port_pkg;

  localparam int unsigned CLOCK_HZ = 100_000_000;

  // Rate selection codes, rate_200 first
  typedef enum logic [3:0] {
    rate_200, rate_300, rate_600, rate_1200, rate_1800, rate_2400,
    rate_4800, rate_9600, rate_19200, rate_38400, rate_57600, rate_115200
  } bit_rate_t;
  localparam int unsigned RATE_COUNT = 12;

  // Character lengths, code 0 is five bits
  typedef enum logic [1:0] {
    five_bit_chars, six_bit_chars, seven_bit_chars, eight_bit_chars
  } char_length_t;

  // Flow policies for the request and ready lines
  typedef enum logic [2:0] {
    auto_key_request, request_forced_low, request_forced_high,
    request_clear_gated, software_driven_lines
  } flow_policy_t;

  // Operating modes
  typedef enum logic {
    normal_mode, extended_mode
  } op_mode_t;

  // Register map, byte addresses
  localparam logic [3:0] CONFIG_ADDR  = 4'h0;
  localparam logic [3:0] LINES_ADDR   = 4'h4;
  localparam logic [3:0] TXDATA_ADDR  = 4'h8;
  localparam logic [3:0] RXDATA_ADDR  = 4'hc;

  // Config field positions
  localparam int unsigned CFG_RATE_LSB   = 0;
  localparam int unsigned CFG_LEN_LSB    = 4;
  localparam int unsigned CFG_POLICY_LSB = 8;
  localparam int unsigned CFG_MODE_BIT   = 12;

  // Lines field positions
  localparam int unsigned LN_RTS_BIT = 0;
  localparam int unsigned LN_DTR_BIT = 1;
  localparam int unsigned LN_CTS_BIT = 4;
  localparam int unsigned LN_DSR_BIT = 5;
  localparam int unsigned LN_DCD_BIT = 6;
  localparam int unsigned LN_RTS_OUT_BIT = 8;
  localparam int unsigned LN_BUSY_BIT    = 9;

  // Tx and rx data/status field positions
  localparam int unsigned ST_TX_FULL_BIT  = 8;
  localparam int unsigned ST_RX_VALID_BIT = 9;
  localparam int unsigned ST_RX_FERR_BIT  = 10;
  localparam int unsigned ST_RX_OVR_BIT   = 11;

  // Reset values
  localparam bit_rate_t    RATE_RESET   = rate_9600;
  localparam char_length_t LEN_RESET    = eight_bit_chars;
  localparam flow_policy_t POLICY_RESET = auto_key_request;
  localparam op_mode_t     MODE_RESET   = normal_mode;

  // Clock cycles per bit for each rate code
  function automatic logic [19:0] bit_cycles(input bit_rate_t r);
    int unsigned bps;
    case (r)
      rate_200:    bps = 200;
      rate_300:    bps = 300;
      rate_600:    bps = 600;
      rate_1200:   bps = 1200;
      rate_1800:   bps = 1800;
      rate_2400:   bps = 2400;
      rate_4800:   bps = 4800;
      rate_9600:   bps = 9600;
      rate_19200:  bps = 19200;
      rate_38400:  bps = 38400;
      rate_57600:  bps = 57600;
      default:     bps = 115200;
    endcase
    return 20'(CLOCK_HZ / bps);
  endfunction : bit_cycles

endpackage : serial_port_pkg

//--- hdl/serial_frame_if.sv
/*
  Interface between the serial port top and its receive shifter.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface serial_frame_if;
  import serial_port_pkg::*;
  logic [19:0]  bit_len;   // Cycles per bit
  char_length_t char_len;  // Active character length
  logic         line;      // Synchronised receive line
  logic         valid;     // One-cycle pulse, character ready
  logic [7:0]   data;      // Received character
  logic         frame_err; // Stop bit sampled low

  modport ctrl (output bit_len, char_len, line, input valid, data, frame_err);
  modport rx   (input bit_len, char_len, line, output valid, data, frame_err);
endinterface : serial_frame_if

//--- hdl/serial_rx_shifter.sv
/*
  Receive shifter: samples each bit mid-cell and assembles a character
  of five to eight bits. Assumes the line is already synchronised.
*/
`timescale 1ns/100ps
module serial_rx_shifter
  import serial_port_pkg::*;
(
  // System
  input  wire logic clock,
  input  wire logic resetn,
  // Frame side
  serial_frame_if.rx fr
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  typedef struct packed {
    rx_state_t   state;
    logic [19:0] cnt;
    logic [2:0]  idx;
    logic [7:0]  shift;
    logic        valid;
    logic [7:0]  data;
    logic        ferr;
  } rx_t;

  rx_t s_q;
  rx_t s_d;

  // Next state of the shifter
  always_comb begin
    s_d       = s_q;
    s_d.valid = 1'b0;
    case (s_q.state)
      RX_IDLE: begin
        if (!fr.line) begin
          s_d.state = RX_START;
          s_d.cnt   = {1'b0, fr.bit_len[19:1]}; // Half cell to mid-bit
        end
      end
      RX_START: begin
        if (s_q.cnt != 20'h0) begin
          s_d.cnt = s_q.cnt - 20'h1;
        end else if (fr.line) begin
          s_d.state = RX_IDLE; // Glitch, not a start bit
        end else begin
          s_d.state = RX_DATA;
          s_d.cnt   = fr.bit_len - 20'h1;
          s_d.idx   = 3'h0;
          s_d.shift = 8'h00;
        end
      end
      RX_DATA: begin
        if (s_q.cnt != 20'h0) begin
          s_d.cnt = s_q.cnt - 20'h1;
        end else begin
          s_d.shift[s_q.idx] = fr.line; // LSB first [R2]
          s_d.cnt            = fr.bit_len - 20'h1;
          if (s_q.idx == {1'b0, fr.char_len} + 3'h4) begin
            s_d.state = RX_STOP;
          end else begin
            s_d.idx = s_q.idx + 3'h1;
          end
        end
      end
      RX_STOP: begin
        if (s_q.cnt != 20'h0) begin
          s_d.cnt = s_q.cnt - 20'h1;
        end else begin
          s_d.state = RX_IDLE;
          s_d.valid = 1'b1;
          s_d.data  = s_q.shift;
          s_d.ferr  = !fr.line;
        end
      end
      default: s_d.state = RX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{state: RX_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign fr.valid     = s_q.valid;
  assign fr.data      = s_q.data;
  assign fr.frame_err = s_q.ferr;

endmodule : serial_rx_shifter

//--- hdl/serial_port.sv
/*
  Serial port with selectable rate, character length and modem-signal
  flow policies, reached through a plain register port.
  Assumes modem inputs and the receive line are asynchronous pins.
*/
// Overview of operation
// R1 - Twelve bit rates, 200 to 115200 selectable
// R2 - Five to eight data bits selectable
// R3 - Auto keying: RTS during transmission only
// R4 - Forced modes hold RTS low or high
// R5 - Clear-gated: raise RTS when CTS inactive
// R6 - Clear-gated: send after CTS, then release
// R7 - Manual: software drives RTS and DTR
// R8 - Normal mode: plain data, no extras
// R9 - Extended mode: frame status beside data
// R10 - Done only after final stop bit leaves
`timescale 1ns/100ps
module serial_port
  import serial_port_pkg::*;
(
  // System
  input  wire logic        clock,
  input  wire logic        resetn,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Serial line
  output logic             txd,
  input  wire logic        rxd,
  // Modem signals, active high
  output logic             rts,
  output logic             dtr,
  input  wire logic        cts,
  input  wire logic        dsr,
  input  wire logic        dcd
);

  typedef enum logic [2:0] {
    TX_IDLE, TX_KEY, TX_START, TX_DATA, TX_STOP
  } tx_state_t;

  typedef struct packed {
    bit_rate_t    rate;
    char_length_t len;
    flow_policy_t policy;
    op_mode_t     mode;
    logic         sw_rts;
    logic         sw_dtr;
    logic [3:0]   sync1_all; // First stage: dcd dsr cts rxd
    logic [3:0]   sync2;
    logic         tx_full;
    logic [7:0]   tx_hold;
    tx_state_t    tx_state;
    logic [19:0]  tx_cnt;
    logic [2:0]   tx_idx;
    logic [7:0]   tx_shift;
    logic         txd;
    logic         rts_out;
    logic         rx_valid;
    logic [7:0]   rx_data;
    logic         rx_ferr;
    logic         rx_ovr;
    logic [31:0]  rdata;
  } port_t;

  port_t s_q;
  port_t s_d;

  serial_frame_if fr ();

  // Receive shifter shares the clock and rate
  serial_rx_shifter u_rx (
    .clock  (clock),
    .resetn (resetn),
    .fr     (fr.rx)
  );

  assign fr.bit_len  = bit_cycles(s_q.rate);            // [R1]
  assign fr.char_len = s_q.len;                          // [R2]
  assign fr.line     = s_q.sync2[0];

  // Synchronised pins: bit 0 rxd, 1 cts, 2 dsr, 3 dcd
  logic cts_s;
  logic dsr_s;
  logic dcd_s;
  logic last_bit;
  assign cts_s = s_q.sync2[1];
  assign dsr_s = s_q.sync2[2];
  assign dcd_s = s_q.sync2[3];
  assign last_bit = (s_q.tx_idx == {1'b0, s_q.len} + 3'h4);

  // Next state of the whole port
  always_comb begin
    s_d           = s_q;
    s_d.sync1_all = {dcd, dsr, cts, rxd};
    s_d.sync2     = s_q.sync1_all;
    s_d.rdata     = 32'h0;

    // Register writes
    if (wr) begin
      case (addr)
        CONFIG_ADDR: begin
          if (wdata[CFG_RATE_LSB +: 4] < 4'(RATE_COUNT)) begin
            s_d.rate = bit_rate_t'(wdata[CFG_RATE_LSB +: 4]);   // [R1]
          end
          s_d.len  = char_length_t'(wdata[CFG_LEN_LSB +: 2]);   // [R2]
          if (wdata[CFG_POLICY_LSB +: 3] <= 3'(software_driven_lines)) begin
            s_d.policy = flow_policy_t'(wdata[CFG_POLICY_LSB +: 3]);
          end
          s_d.mode = op_mode_t'(wdata[CFG_MODE_BIT]);
        end
        LINES_ADDR: begin
          s_d.sw_rts = wdata[LN_RTS_BIT];
          s_d.sw_dtr = wdata[LN_DTR_BIT];
        end
        TXDATA_ADDR: begin
          if (!s_q.tx_full) begin // Write while full is dropped
            s_d.tx_full = 1'b1;
            s_d.tx_hold = wdata[7:0];
          end
        end
        default: ;
      endcase
    end

    // Register reads, data shown the next cycle
    if (rd) begin
      case (addr)
        CONFIG_ADDR: begin
          s_d.rdata[CFG_RATE_LSB +: 4]   = s_q.rate;
          s_d.rdata[CFG_LEN_LSB +: 2]    = s_q.len;
          s_d.rdata[CFG_POLICY_LSB +: 3] = s_q.policy;
          s_d.rdata[CFG_MODE_BIT]        = s_q.mode;
        end
        LINES_ADDR: begin
          s_d.rdata[LN_RTS_BIT]     = s_q.sw_rts;
          s_d.rdata[LN_DTR_BIT]     = s_q.sw_dtr;
          s_d.rdata[LN_CTS_BIT]     = cts_s;           // [R7]
          s_d.rdata[LN_DSR_BIT]     = dsr_s;
          s_d.rdata[LN_DCD_BIT]     = dcd_s;
          s_d.rdata[LN_RTS_OUT_BIT] = s_q.rts_out;
          s_d.rdata[LN_BUSY_BIT]    = s_q.tx_state != TX_IDLE || s_q.tx_full;
        end
        TXDATA_ADDR: begin
          s_d.rdata[ST_TX_FULL_BIT]  = s_q.tx_full;
          s_d.rdata[ST_RX_VALID_BIT] = s_q.rx_valid;
        end
        RXDATA_ADDR: begin
          s_d.rdata[7:0] = s_q.rx_data;
          s_d.rdata[ST_RX_VALID_BIT] = s_q.rx_valid;
          if (s_q.mode == extended_mode) begin // [R9]
            s_d.rdata[ST_RX_FERR_BIT] = s_q.rx_ferr;
            s_d.rdata[ST_RX_OVR_BIT]  = s_q.rx_ovr;
          end                                  // Normal hides them [R8]
          s_d.rx_valid = 1'b0;
          s_d.rx_ovr   = 1'b0;
        end
        default: ;
      endcase
    end

    // New character wins over the read clear
    if (fr.valid) begin
      s_d.rx_ovr   = s_q.rx_valid && !(rd && addr == RXDATA_ADDR) ? 1'b1 : s_d.rx_ovr;
      s_d.rx_valid = 1'b1;
      s_d.rx_data  = fr.data;
      s_d.rx_ferr  = fr.frame_err;
    end

    // Transmitter
    case (s_q.tx_state)
      TX_IDLE: begin
        s_d.txd = 1'b1;
        if (s_q.tx_full) begin
          s_d.tx_state = TX_KEY;
        end
      end
      TX_KEY: begin
        // Clear-gated waits for the far end [R6]
        if (s_q.policy != request_clear_gated || cts_s) begin
          s_d.tx_state = TX_START;
          s_d.tx_shift = s_q.tx_hold;
          s_d.tx_full  = 1'b0;
          s_d.tx_cnt   = fr.bit_len - 20'h1;
          s_d.txd      = 1'b0;
        end
      end
      TX_START: begin
        if (s_q.tx_cnt != 20'h0) begin
          s_d.tx_cnt = s_q.tx_cnt - 20'h1;
        end else begin
          s_d.tx_state = TX_DATA;
          s_d.tx_idx   = 3'h0;
          s_d.txd      = s_q.tx_shift[0];
          s_d.tx_cnt   = fr.bit_len - 20'h1;
        end
      end
      TX_DATA: begin
        if (s_q.tx_cnt != 20'h0) begin
          s_d.tx_cnt = s_q.tx_cnt - 20'h1;
        end else begin
          s_d.tx_cnt = fr.bit_len - 20'h1;
          if (last_bit) begin                          // [R2]
            s_d.tx_state = TX_STOP;
            s_d.txd      = 1'b1;
          end else begin
            s_d.tx_idx = s_q.tx_idx + 3'h1;
            s_d.txd    = s_q.tx_shift[s_q.tx_idx + 3'h1];
          end
        end
      end
      TX_STOP: begin
        if (s_q.tx_cnt != 20'h0) begin
          s_d.tx_cnt = s_q.tx_cnt - 20'h1;
        end else begin
          // Queued character keys at once, so RTS never dips between frames [R10]
          s_d.tx_state = s_d.tx_full ? TX_KEY : TX_IDLE;
        end
      end
      default: s_d.tx_state = TX_IDLE;
    endcase

    // Request line per policy; queued character keeps it keyed
    case (s_q.policy)
      auto_key_request:      s_d.rts_out = s_d.tx_state != TX_IDLE;     // [R3]
      request_clear_gated:   s_d.rts_out = s_d.tx_state != TX_IDLE;     // [R5] [R6]
      request_forced_low:    s_d.rts_out = 1'b0;                        // [R4]
      request_forced_high:   s_d.rts_out = 1'b1;                        // [R4]
      software_driven_lines: s_d.rts_out = s_d.sw_rts;                  // [R7]
      default:               s_d.rts_out = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{rate: RATE_RESET, len: LEN_RESET, policy: POLICY_RESET,
               mode: MODE_RESET, tx_state: TX_IDLE, txd: 1'b1,
               sync1_all: 4'hf, sync2: 4'hf, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign txd   = s_q.txd;
  assign rts   = s_q.rts_out;
  assign dtr   = (s_q.policy == software_driven_lines) ? s_q.sw_dtr : 1'b1; // [R7]

endmodule : serial_port

//--- sim/serial_port_props.sv
/*
  Checker for the serial port: flow-policy and keying relations at the
  top ports. Assumes it is bound to serial_port and shadows config writes.
*/
`timescale 1ns/100ps
module serial_port_props
  import serial_port_pkg::*;
(
  // System
  input wire logic        clock,
  input wire logic        resetn,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Serial and modem lines
  input wire logic        txd,
  input wire logic        rxd,
  input wire logic        rts,
  input wire logic        dtr,
  input wire logic        cts,
  input wire logic        dsr,
  input wire logic        dcd
);
  localparam int BL = CLOCK_HZ / 115200; // Bit time, only judged at the fastest rate
  flow_policy_t pol_q;
  logic         fast_q;
  logic [3:0]   age_q;
  logic [19:0]  hi_q;
  logic         cfg_wr;
  logic         keyed;
  logic         steady;
  logic         txd_p;
  logic         queued_q;
  // Decoded write and policy class
  assign cfg_wr = wr && addr == CONFIG_ADDR;
  assign keyed  = pol_q == auto_key_request || pol_q == request_clear_gated;
  assign steady = age_q >= 4'h2;
  // Shadow config; refused codes keep the old field, as the port does
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pol_q  <= POLICY_RESET;
      fast_q <= 1'b0;
      age_q  <= 4'hf;
      hi_q   <= 20'h0;
      txd_p  <= 1'b1;
      queued_q <= 1'b0;
    end else begin
      // Character written but not yet started; waiting for clear may hold RTS up
      txd_p <= txd;
      if (wr && addr == TXDATA_ADDR) queued_q <= 1'b1;
      else if (txd_p && !txd) queued_q <= 1'b0;
      if (cfg_wr && wdata[10:8] <= 3'h4) pol_q <= flow_policy_t'(wdata[10:8]);
      if (cfg_wr && wdata[3:0] <= 4'hb) fast_q <= wdata[3:0] == 4'hb;
      age_q <= cfg_wr ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
      hi_q  <= !txd ? 20'h0 : (hi_q == 20'hfffff ? hi_q : hi_q + 20'h1);
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_forced_low: assert property (steady && pol_q == request_forced_low |-> !rts)
    else $error("request not held low");
  a_forced_high: assert property (steady && pol_q == request_forced_high |-> rts)
    else $error("request not held high");
  a_dtr_held: assert property (steady && pol_q != software_driven_lines |-> dtr)
    else $error("ready line dropped outside manual");
  a_auto_start: assert property ($fell(txd) && pol_q == auto_key_request |-> rts)
    else $error("start bit without request");
  a_auto_raise: assert property (wr && addr == TXDATA_ADDR && steady
    && pol_q == auto_key_request |-> ##[1:4] rts) else $error("request late");
  a_gated_raise: assert property (wr && addr == TXDATA_ADDR && steady && !cts
    && pol_q == request_clear_gated |-> ##[1:4] rts) else $error("gated request late");
  a_gated_start: assert property ($fell(txd) && pol_q == request_clear_gated
    |-> rts && cts && $past(cts, 2)) else $error("sent before clear");
  a_stop_whole: assert property ($fell(rts) && keyed && fast_q && steady
    |-> hi_q >= 20'(BL)) else $error("request dropped inside stop bit");
  a_key_prompt: assert property (keyed && fast_q && age_q > 4'h4
    && !queued_q && hi_q > 20'(9 * BL + 4) |-> !rts) else $error("request held after frame");
  // Main scenarios reached
  c_auto_frame: cover property ($fell(txd) && pol_q == auto_key_request);
  c_gated_frame: cover property ($fell(txd) && pol_q == request_clear_gated);
  c_key_drop: cover property ($fell(rts) && keyed);
endmodule : serial_port_props

bind serial_port serial_port_props i_props (.clock(clock), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txd(txd), .rxd(rxd), .rts(rts),
  .dtr(dtr), .cts(cts), .dsr(dsr), .dcd(dcd));

//--- sim/line_modem_model.sv
/*
  Far-side modem model: answers the request line with clear after a
  turnaround, decodes sent characters and sends characters of its own.
  Assumes the bench sets bit time, character length and turnaround.
*/
`timescale 1ns/100ps
module line_modem_model (
  // System
  input  wire logic clock,
  // From the port
  input  wire logic txd,
  input  wire logic rts,
  // To the port
  output logic      rxd,
  output logic      cts,
  output logic      dsr,
  output logic      dcd
);
  int         bit_len = 868;
  int         nbits   = 8;
  int         turn    = 3;
  int         wait_q  = 0;
  int         n_got   = 0;
  logic [7:0] got;
  // Idle line high, carrier and set ready present
  initial begin
    rxd = 1'b1;
    cts = 1'b0;
    dsr = 1'b1;
    dcd = 1'b1;
  end
  // Clear follows request after a turnaround, drops with it at once
  always @(posedge clock) begin
    if (!rts) begin
      wait_q <= 0;
      cts    <= 1'b0;
    end else if (wait_q < turn) begin
      wait_q <= wait_q + 1;
    end else begin
      cts <= 1'b1;
    end
  end
  // Decoder samples mid-cell, LSB first; counts at mid stop bit
  always begin
    @(negedge txd);
    repeat (bit_len / 2) @(posedge clock);
    got = 8'h0;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_len) @(posedge clock);
      got[i] = txd;
    end
    repeat (bit_len) @(posedge clock);
    n_got++;
  end
  // Sends one character; a low stop bit makes a framing fault
  task automatic send(input logic [7:0] c, input logic stop);
    rxd <= 1'b0;
    repeat (bit_len) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      rxd <= c[i];
      repeat (bit_len) @(posedge clock);
    end
    rxd <= stop;
    repeat (bit_len) @(posedge clock);
    rxd <= 1'b1;
  endtask : send
endmodule : line_modem_model

//--- sim/test_serial_port.sv
/*
  Testbench for the serial port: register tasks, flow policies, frames.
  Assumes the modem model on the far side and a 100 MHz clock.
*/
`timescale 1ns/100ps
module test_serial_port
  import serial_port_pkg::*;
;
  logic        clock, resetn, wr, rd, txd, rxd, rts, dtr, cts, dsr, dcd;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata;
  int          fails = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          bl = CLOCK_HZ / 115200;
  serial_port i_dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .txd(txd), .rxd(rxd), .rts(rts), .dtr(dtr), .cts(cts),
    .dsr(dsr), .dcd(dcd));
  line_modem_model i_modem (.clock(clock), .txd(txd), .rts(rts), .rxd(rxd), .cts(cts),
    .dsr(dsr), .dcd(dcd));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_write
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask : reg_read
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  // Bounded wait for the modem to count a character
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (i_modem.n_got != n && k < 20000) begin
      settle(1);
      k++;
    end
    if (k == 20000) fails++;
  endtask : wait_got
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard well above the expected run of about 42000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    {resetn, wr, rd, addr, wdata} = '0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    reg_read(CONFIG_ADDR, 32'h37, "config reset");
    for (int r = 0; r < RATE_COUNT; r++) begin
      reg_write(CONFIG_ADDR, 32'h30 | 32'(r));
      reg_read(CONFIG_ADDR, 32'h30 | 32'(r), "rate code");
    end
    for (int l = 0; l < 4; l++) begin
      reg_write(CONFIG_ADDR, 32'hb | 32'(l << 4));
      reg_read(CONFIG_ADDR, 32'hb | 32'(l << 4), "length code");
    end
    reg_write(CONFIG_ADDR, 32'h3c);
    reg_read(CONFIG_ADDR, 32'h3b, "refused rate");
    // Auto keying, five-bit character
    i_modem.bit_len = bl;
    i_modem.nbits = 5;
    reg_write(CONFIG_ADDR, 32'h00b);
    settle(2);
    reg_write(TXDATA_ADDR, 32'h15);
    settle(4);
    check("auto request", 32'(rts), 32'h1);
    wait_got(1);
    check("five-bit char", 32'(i_modem.got), 32'h15);
    check("request in stop", 32'(rts), 32'h1);
    settle(bl);
    check("auto release", 32'(rts), 32'h0);
    // Forced low still sends, request stays off
    i_modem.nbits = 8;
    reg_write(CONFIG_ADDR, 32'h13b);
    reg_write(TXDATA_ADDR, 32'h5a);
    wait_got(2);
    check("eight-bit char", 32'(i_modem.got), 32'h5a);
    check("forced low", 32'(rts), 32'h0);
    reg_write(CONFIG_ADDR, 32'h23b);
    settle(3);
    check("forced high", 32'(rts), 32'h1);
    // Clear-gated with a slow modem
    i_modem.turn = 200;
    reg_write(CONFIG_ADDR, 32'h33b);
    settle(10);
    reg_write(TXDATA_ADDR, 32'ha5);
    settle(100);
    check("gated request", 32'(rts), 32'h1);
    check("held for clear", 32'(txd), 32'h1);
    wait_got(3);
    check("gated char", 32'(i_modem.got), 32'ha5);
    settle(bl);
    check("gated release", 32'(rts), 32'h0);
    // Manual lines under software control
    i_modem.turn = 3;
    reg_write(CONFIG_ADDR, 32'h43b);
    reg_write(LINES_ADDR, 32'h1);
    settle(2);
    check("manual request", {30'h0, dtr, rts}, 32'h1);
    settle(10);
    reg_read(LINES_ADDR, 32'h171, "manual lines");
    reg_write(LINES_ADDR, 32'h2);
    settle(2);
    check("manual ready", {30'h0, dtr, rts}, 32'h2);
    // Receive in normal mode, then a framing fault in extended mode
    reg_write(CONFIG_ADDR, 32'h03b);
    i_modem.send(8'h3c, 1'b1);
    settle(10);
    reg_read(RXDATA_ADDR, 32'h23c, "normal receive");
    reg_write(CONFIG_ADDR, 32'h103b);
    i_modem.send(8'h5a, 1'b0);
    settle(10);
    reg_read(RXDATA_ADDR, 32'h65a, "extended receive");
    finish_test();
  end
endmodule : test_serial_port
